// ---- rtl/usbira_pkg.sv ----
// Shared constants and types for the indirect USB register access port
package usbira_pkg;
   // ----------------------------------------------------------------
   // CPU-side special function registers
   // ----------------------------------------------------------------
   localparam int SFR_DW = 8;
   localparam logic SFR_SEL_ADR = 1'b0;
   localparam logic SFR_SEL_DAT = 1'b1;
   localparam int BUSY_BIT = 7;
   localparam int AUTO_BIT = 6;
   localparam int TGT_W = 6;
   localparam logic [7:0] ADR_RST = 8'h00;
   localparam logic [7:0] DAT_RST = 8'h00;
   // ----------------------------------------------------------------
   // Core register numbers
   // ----------------------------------------------------------------
   localparam logic [5:0] CR_INDEX = 6'h00;
   localparam logic [5:0] CR_GEN_LO = 6'h01;
   localparam logic [5:0] CR_GEN_HI = 6'h0F;
   localparam logic [5:0] CR_EP_CSR1 = 6'h10;
   localparam logic [5:0] CR_EP_CSR2 = 6'h11;
   localparam logic [5:0] CR_EP_CNT = 6'h12;
   localparam logic [5:0] CR_FIFO = 6'h20;
   localparam logic [7:0] CORE_RST = 8'h00;
   // ----------------------------------------------------------------
   // Core sizes and timing
   // ----------------------------------------------------------------
   localparam int NUM_EP = 4;
   localparam int FIFO_BYTES = 1024;
   localparam int CORE_LAT = 2;
   // ----------------------------------------------------------------
   // Controller registers on Avalon-MM
   // ----------------------------------------------------------------
   localparam logic [3:0] AV_CMD = 4'h0;
   localparam logic [3:0] AV_WDATA = 4'h4;
   localparam logic [3:0] AV_STAT = 4'h8;
   localparam logic [3:0] AV_RDATA = 4'hC;
   localparam int CMD_START_BIT = 0;
   localparam int CMD_WR_BIT = 1;
   localparam int CMD_AUTO_BIT = 2;
   localparam int CMD_TGT_LSB = 8;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   // ----------------------------------------------------------------
   // State types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      OP_IDLE = 2'b00,
      OP_WR = 2'b01,
      OP_RD = 2'b10
   } usbira_op_t;
   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_POLL = 3'b001,
      H_WADR = 3'b010,
      H_WDAT = 3'b011,
      H_POLL2 = 3'b100,
      H_RDAT = 3'b101
   } usbira_hst_t;
endpackage

// ---- rtl/usbira_if.sv ----
// Special function register bus between the CPU and the access port
`timescale 1ns/10ps
`default_nettype none
interface usbira_if;
   logic sfr_sel;
   logic sfr_wr;
   logic sfr_rd;
   logic [7:0] sfr_wdata;
   logic [7:0] sfr_rdata;
   logic usb_clk_on;
   modport dev (input sfr_sel, input sfr_wr, input sfr_rd, input sfr_wdata,
                output sfr_rdata, output usb_clk_on);
   modport cpu (output sfr_sel, output sfr_wr, output sfr_rd, output sfr_wdata,
                input sfr_rdata, input usb_clk_on);
endinterface
`default_nettype wire

// ---- rtl/usbira_fifo.sv ----
// Shared endpoint FIFO storage split evenly among the endpoints
`timescale 1ns/10ps
`default_nettype none
module usbira_fifo import usbira_pkg::*; #(
   parameter int NEP = NUM_EP,
   parameter int FBYTES = FIFO_BYTES
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   // Access to the selected endpoint
   input wire logic [$clog2(NEP)-1:0] i_ep,
   input wire logic i_push,
   input wire logic i_pop,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   output logic [$clog2(FBYTES/NEP):0] o_count
);
   localparam int EPW = $clog2(NEP);
   localparam int PW = $clog2(FBYTES / NEP);
   logic [7:0] mem [FBYTES];
   logic [PW-1:0] wp_r [NEP];
   logic [PW-1:0] rp_r [NEP];
   logic [PW:0] cnt_r [NEP];
   logic do_push;
   logic do_pop;
   // Full and empty protect the unread bytes in the endpoint's own share of the storage
   assign do_push = i_push && (cnt_r[i_ep] != (PW+1)'(FBYTES / NEP));
   assign do_pop = i_pop && (cnt_r[i_ep] != '0);
   // Show-ahead: the head byte is visible before the pop
   assign o_rdata = mem[{i_ep, rp_r[i_ep]}];
   assign o_count = cnt_r[i_ep];
   always_ff @(posedge i_clk_sys) begin
      if (do_push) begin
         mem[{i_ep, wp_r[i_ep]}] <= i_wdata;
      end
   end
   // ----------------------------------------------------------------
   // Per-endpoint pointers
   // ----------------------------------------------------------------
   for (genvar e = 0; e < NEP; e++) begin : g_ep
      logic sel;
      logic [PW-1:0] wp_nxt;
      logic [PW-1:0] rp_nxt;
      logic [PW:0] cnt_nxt;
      always_comb begin
         sel = (i_ep == EPW'(e));
         wp_nxt = wp_r[e];
         rp_nxt = rp_r[e];
         cnt_nxt = cnt_r[e];
         if (sel && do_push) begin
            wp_nxt = wp_r[e] + 1'b1;
         end
         if (sel && do_pop) begin
            rp_nxt = rp_r[e] + 1'b1;
         end
         if (sel && do_push && !do_pop) begin
            cnt_nxt = cnt_r[e] + 1'b1;
         end else if (sel && do_pop && !do_push) begin
            cnt_nxt = cnt_r[e] - 1'b1;
         end
      end
      always_ff @(posedge i_clk_sys or negedge i_resetn) begin
         if (!i_resetn) begin
            wp_r[e] <= '0;
            rp_r[e] <= '0;
            cnt_r[e] <= '0;
         end else begin
            wp_r[e] <= wp_nxt;
            rp_r[e] <= rp_nxt;
            cnt_r[e] <= cnt_nxt;
         end
      end
   end
endmodule // usbira_fifo
`default_nettype wire

// ---- rtl/usbira_dev.sv ----
// Indirect register access port of the USB function controller
//
// Notes on behaviour
// RL1 - Core registers reached only through address/data
// RL2 - Busy flag in address bit 7
// RL3 - CPU reselects target only when it differs; code also reselects on auto mode change and every manual read
// RL4 - Manual read: write busy, await clear
// RL5 - Auto-read fetches without busy written by hand
// RL6 - Index register selects endpoint CSRs
// RL7 - FIFO reached through indexed indirect register
// RL8 - One kilobyte FIFO shared by endpoints
// RL9 - CPU accesses only while USB clock runs
// RL10 - Busy held until core operation completes
//
// The Avalon-MM register port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
module usbira_dev import usbira_pkg::*; #(
   parameter int CORE_LAT_P = CORE_LAT,
   parameter int NEP = NUM_EP,
   parameter int FBYTES = FIFO_BYTES
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   // CPU special function register bus
   usbira_if.dev sfr,
   // USB core side
   input wire logic i_usb_clk_on,
   output logic o_busy,
   output logic [$clog2(NEP)-1:0] o_index
);
   localparam int EPW = $clog2(NEP);
   localparam int PW = $clog2(FBYTES / NEP);

   if (CORE_LAT_P < 1 || CORE_LAT_P > 255 || NEP < 2 || NEP > 64 ||
       (NEP & (NEP - 1)) != 0 || FBYTES % NEP != 0 ||
       ((FBYTES / NEP) & (FBYTES / NEP - 1)) != 0) begin : g_chk
      $error("usbira_dev: unsupported parameter values");
   end

   // ----------------------------------------------------------------
   // USB clock status synchroniser
   // ----------------------------------------------------------------
   logic usbon_s1_r;
   logic usbon_s2_r;
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         usbon_s1_r <= 1'b0;
         usbon_s2_r <= 1'b0;
      end else begin
         usbon_s1_r <= i_usb_clk_on;
         usbon_s2_r <= usbon_s1_r;
      end
   end
   assign sfr.usb_clk_on = usbon_s2_r;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [7:0] adr_r;
   logic [7:0] adr_nxt;
   logic [7:0] dat_r;
   logic [7:0] dat_nxt;
   logic [EPW-1:0] idx_r;
   logic [EPW-1:0] idx_nxt;
   logic [7:0] gen_r [15:1];
   logic [7:0] gen_nxt [15:1];
   logic [7:0] csr1_r [NEP];
   logic [7:0] csr1_nxt [NEP];
   logic [7:0] csr2_r [NEP];
   logic [7:0] csr2_nxt [NEP];
   usbira_op_t op_r;
   usbira_op_t op_nxt;
   logic [7:0] lat_r;
   logic [7:0] lat_nxt;
   logic [TGT_W-1:0] tgt;
   logic busy;
   logic wr_adr;
   logic wr_dat;
   logic rd_dat;
   logic start_rd;
   logic fifo_push;
   logic fifo_pop;
   logic [7:0] fifo_rdata;
   logic [PW:0] fifo_cnt;
   logic [7:0] core_rdata;

   assign tgt = adr_r[TGT_W-1:0];
   assign busy = adr_r[BUSY_BIT];
   // Accesses that start a transfer are dropped while busy
   assign wr_adr = sfr.sfr_wr && sfr.sfr_sel == SFR_SEL_ADR && !busy; // see RL2
   assign wr_dat = sfr.sfr_wr && sfr.sfr_sel == SFR_SEL_DAT && !busy; // see RL2
   assign rd_dat = sfr.sfr_rd && sfr.sfr_sel == SFR_SEL_DAT && !busy;
   // Only the two registers are visible to the CPU
   assign sfr.sfr_rdata = (sfr.sfr_sel == SFR_SEL_ADR) ? adr_r : dat_r; // see RL1
   assign o_busy = busy;
   assign o_index = idx_r;

   // ----------------------------------------------------------------
   // Endpoint FIFO storage
   // ----------------------------------------------------------------
   usbira_fifo #(
      .NEP(NEP),
      .FBYTES(FBYTES)
   ) u_fifo (
      .i_clk_sys(i_clk_sys),
      .i_resetn(i_resetn),
      .i_ep(idx_r),
      .i_push(fifo_push),
      .i_pop(fifo_pop),
      .i_wdata(dat_r),
      .o_rdata(fifo_rdata),
      .o_count(fifo_cnt)
   ); // see RL8

   // ----------------------------------------------------------------
   // Core register read mux
   // ----------------------------------------------------------------
   always_comb begin
      case (tgt)
         CR_INDEX: core_rdata = 8'(idx_r);
         CR_EP_CSR1: core_rdata = csr1_r[idx_r]; // see RL6
         CR_EP_CSR2: core_rdata = csr2_r[idx_r]; // see RL6
         // Counts above 255 saturate in the 8-bit view
         CR_EP_CNT: core_rdata = (fifo_cnt > (PW+1)'(8'hFF)) ? 8'hFF : 8'(fifo_cnt);
         CR_FIFO: core_rdata = fifo_rdata; // see RL7
         default: begin
            if (tgt >= CR_GEN_LO && tgt <= CR_GEN_HI) begin
               core_rdata = gen_r[tgt[3:0]];
            end else begin
               core_rdata = 8'h00;
            end
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Transfer control
   // ----------------------------------------------------------------
   always_comb begin
      adr_nxt = adr_r;
      dat_nxt = dat_r;
      idx_nxt = idx_r;
      gen_nxt = gen_r;
      csr1_nxt = csr1_r;
      csr2_nxt = csr2_r;
      op_nxt = op_r;
      lat_nxt = lat_r;
      fifo_push = 1'b0;
      fifo_pop = 1'b0;
      start_rd = 1'b0;
      // The core side only advances while its clock runs
      if (op_r != OP_IDLE && usbon_s2_r) begin
         if (lat_r > 8'h01) begin
            lat_nxt = lat_r - 8'h01;
         end else begin
            op_nxt = OP_IDLE;
            adr_nxt[BUSY_BIT] = 1'b0; // see RL10
            if (op_r == OP_WR) begin
               case (tgt)
                  CR_INDEX: idx_nxt = dat_r[EPW-1:0]; // see RL6
                  CR_EP_CSR1: csr1_nxt[idx_r] = dat_r;
                  CR_EP_CSR2: csr2_nxt[idx_r] = dat_r;
                  CR_FIFO: fifo_push = 1'b1; // see RL7
                  default: begin
                     if (tgt >= CR_GEN_LO && tgt <= CR_GEN_HI) begin
                        gen_nxt[tgt[3:0]] = dat_r;
                     end
                  end
               endcase
            end else begin
               dat_nxt = core_rdata;
               fifo_pop = (tgt == CR_FIFO); // see RL7
            end
         end
      end
      if (wr_adr) begin
         adr_nxt[AUTO_BIT:0] = sfr.sfr_wdata[AUTO_BIT:0]; // see RL1
         // Selecting a target in auto-read mode fetches it at once
         start_rd = sfr.sfr_wdata[BUSY_BIT] || sfr.sfr_wdata[AUTO_BIT]; // see RL4
      end
      if (rd_dat && adr_r[AUTO_BIT]) begin
         start_rd = 1'b1; // see RL5
      end
      if (wr_dat) begin
         dat_nxt = sfr.sfr_wdata;
         op_nxt = OP_WR;
         lat_nxt = 8'(CORE_LAT_P);
         adr_nxt[BUSY_BIT] = 1'b1; // see RL10
      end else if (start_rd) begin
         op_nxt = OP_RD;
         lat_nxt = 8'(CORE_LAT_P);
         adr_nxt[BUSY_BIT] = 1'b1; // see RL10
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         adr_r <= ADR_RST;
         dat_r <= DAT_RST;
         idx_r <= '0;
         gen_r <= '{default: CORE_RST};
         csr1_r <= '{default: CORE_RST};
         csr2_r <= '{default: CORE_RST};
         op_r <= OP_IDLE;
         lat_r <= 8'h00;
      end else begin
         adr_r <= adr_nxt;
         dat_r <= dat_nxt;
         idx_r <= idx_nxt;
         gen_r <= gen_nxt;
         csr1_r <= csr1_nxt;
         csr2_r <= csr2_nxt;
         op_r <= op_nxt;
         lat_r <= lat_nxt;
      end
   end
endmodule // usbira_dev
`default_nettype wire

// ---- rtl/usbira_cpu.sv ----
// CPU-side controller that runs indirect transfers on Avalon-MM orders
`timescale 1ns/10ps
`default_nettype none
module usbira_cpu import usbira_pkg::*; (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   // Avalon-MM slave
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Special function register bus
   usbira_if.cpu sfr
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   usbira_hst_t st_r;
   usbira_hst_t st_nxt;
   logic wr_r;
   logic wr_nxt;
   logic auto_r;
   logic auto_nxt;
   logic [TGT_W-1:0] tgt_r;
   logic [TGT_W-1:0] tgt_nxt;
   logic [7:0] wdat_r;
   logic [7:0] wdat_nxt;
   logic [7:0] rdat_r;
   logic [7:0] rdat_nxt;
   logic done_r;
   logic done_nxt;
   logic selv_r;
   logic selv_nxt;
   logic [TGT_W-1:0] selt_r;
   logic [TGT_W-1:0] selt_nxt;
   logic sela_r;
   logic sela_nxt;
   logic rvalid_r;
   logic rvalid_nxt;
   logic [31:0] rd_r;
   logic [31:0] rd_nxt;
   logic match;
   logic idle_ok;

   assign match = selv_r && selt_r == tgt_r && sela_r == auto_r; // see RL3
   assign idle_ok = sfr.usb_clk_on && !sfr.sfr_rdata[BUSY_BIT];
   assign o_avs_waitrequest = i_avs_read && !rvalid_r;
   assign o_avs_readdata = rd_r;

   // ----------------------------------------------------------------
   // Bus drive
   // ----------------------------------------------------------------
   always_comb begin
      sfr.sfr_sel = SFR_SEL_ADR;
      sfr.sfr_wr = 1'b0;
      sfr.sfr_rd = 1'b0;
      sfr.sfr_wdata = 8'h00;
      case (st_r)
         // Every strobe stays off the bus while the USB clock is stopped
         H_POLL, H_POLL2: sfr.sfr_rd = sfr.usb_clk_on; // see RL9
         H_WADR: begin
            sfr.sfr_wr = sfr.usb_clk_on; // see RL9
            sfr.sfr_wdata = {!wr_r && !auto_r, auto_r, tgt_r}; // see RL4
         end
         H_WDAT: begin
            sfr.sfr_sel = SFR_SEL_DAT;
            sfr.sfr_wr = sfr.usb_clk_on; // see RL9
            sfr.sfr_wdata = wdat_r;
         end
         H_RDAT: begin
            sfr.sfr_sel = SFR_SEL_DAT;
            sfr.sfr_rd = sfr.usb_clk_on; // see RL9
         end
         default: sfr.sfr_sel = SFR_SEL_ADR;
      endcase
   end

   // ----------------------------------------------------------------
   // Sequencer and registers
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      wr_nxt = wr_r;
      auto_nxt = auto_r;
      tgt_nxt = tgt_r;
      wdat_nxt = wdat_r;
      rdat_nxt = rdat_r;
      done_nxt = done_r;
      selv_nxt = selv_r;
      selt_nxt = selt_r;
      sela_nxt = sela_r;
      rvalid_nxt = i_avs_read && !rvalid_r;
      rd_nxt = rd_r;
      if (i_avs_write && i_avs_address == AV_STAT && i_avs_writedata[STAT_DONE_BIT]) begin
         done_nxt = 1'b0;
      end
      if (i_avs_write && i_avs_address == AV_WDATA && st_r == H_IDLE) begin
         wdat_nxt = i_avs_writedata[7:0];
      end
      case (st_r)
         H_IDLE: begin
            if (i_avs_write && i_avs_address == AV_CMD && i_avs_writedata[CMD_START_BIT]) begin
               wr_nxt = i_avs_writedata[CMD_WR_BIT];
               auto_nxt = i_avs_writedata[CMD_AUTO_BIT];
               tgt_nxt = i_avs_writedata[CMD_TGT_LSB +: TGT_W];
               st_nxt = H_POLL;
            end
         end
         H_POLL: begin
            if (idle_ok) begin // see RL2
               if (wr_r) begin
                  st_nxt = match ? H_WDAT : H_WADR; // see RL3
               end else begin
                  st_nxt = (match && auto_r) ? H_POLL2 : H_WADR; // see RL5
               end
            end
         end
         H_WADR: begin
            // The clock may stop after the poll; the strobe then waits
            if (sfr.usb_clk_on) begin // see RL9
               selv_nxt = 1'b1;
               selt_nxt = tgt_r;
               sela_nxt = auto_r;
               // An auto-read select makes the port busy, so writes poll again
               st_nxt = wr_r ? H_POLL : H_POLL2;
            end
         end
         H_WDAT: begin
            if (sfr.usb_clk_on) begin // see RL9
               done_nxt = 1'b1;
               st_nxt = H_IDLE;
            end
         end
         H_POLL2: begin
            if (idle_ok) begin // see RL4
               st_nxt = H_RDAT;
            end
         end
         H_RDAT: begin
            if (sfr.usb_clk_on) begin // see RL9
               rdat_nxt = sfr.sfr_rdata;
               done_nxt = 1'b1;
               st_nxt = H_IDLE;
            end
         end
         default: st_nxt = H_IDLE;
      endcase
      if (i_avs_read && !rvalid_r) begin
         case (i_avs_address)
            AV_CMD: rd_nxt = (32'(auto_r) << CMD_AUTO_BIT) | (32'(wr_r) << CMD_WR_BIT) | (32'(tgt_r) << CMD_TGT_LSB);
            AV_WDATA: rd_nxt = 32'(wdat_r);
            AV_STAT: rd_nxt = 32'({done_r, st_r != H_IDLE});
            AV_RDATA: rd_nxt = 32'(rdat_r);
            default: rd_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         st_r <= H_IDLE;
         wr_r <= 1'b0;
         auto_r <= 1'b0;
         tgt_r <= '0;
         wdat_r <= 8'h00;
         rdat_r <= 8'h00;
         done_r <= 1'b0;
         selv_r <= 1'b0;
         selt_r <= '0;
         sela_r <= 1'b0;
         rvalid_r <= 1'b0;
         rd_r <= 32'h0000_0000;
      end else begin
         st_r <= st_nxt;
         wr_r <= wr_nxt;
         auto_r <= auto_nxt;
         tgt_r <= tgt_nxt;
         wdat_r <= wdat_nxt;
         rdat_r <= rdat_nxt;
         done_r <= done_nxt;
         selv_r <= selv_nxt;
         selt_r <= selt_nxt;
         sela_r <= sela_nxt;
         rvalid_r <= rvalid_nxt;
         rd_r <= rd_nxt;
      end
   end
endmodule // usbira_cpu
`default_nettype wire

// ---- sim/usbira_sva.sv ----
// Assertions on the special function register link between the two ends
`timescale 1ns/10ps
`default_nettype none
module usbira_sva (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   // Link signals
   input wire logic sfr_sel,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic usb_clk_on,
   // Device side
   input wire logic i_usb_clk_on,
   input wire logic o_busy
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);

   AST_BUSY_MIRROR: assert property (!sfr_sel |-> sfr_rdata[7] == o_busy)
      else $error("address read does not show busy");
   AST_NO_WR_BUSY: assert property (sfr_wr |-> !o_busy)
      else $error("link write while busy");
   AST_RD_WR_EXCL: assert property (!(sfr_rd && sfr_wr))
      else $error("read and write strobes together");
   AST_FETCH_START: assert property (sfr_wr && !sfr_sel && (sfr_wdata[7] || sfr_wdata[6]) |=> o_busy)
      else $error("fetch request did not raise busy");
   AST_DATA_WR_BUSY: assert property (sfr_wr && sfr_sel |=> o_busy)
      else $error("data write did not raise busy");
   AST_BUSY_HOLD: assert property ($rose(o_busy) |=> o_busy)
      else $error("busy dropped too early");
   AST_BUSY_DONE: assert property (($rose(o_busy) && usb_clk_on) ##1 usb_clk_on [*3] |-> !o_busy)
      else $error("busy held too long");
   AST_FROZEN: assert property (o_busy && !usb_clk_on |=> o_busy)
      else $error("operation advanced without usb clock");
   AST_CLK_GATE: assert property (sfr_wr |-> usb_clk_on)
      else $error("link write with usb clock stopped");
   AST_CLK_SYNC: assert property (i_usb_clk_on ##1 i_usb_clk_on |=> usb_clk_on)
      else $error("usb clock status not synchronised");

   COV_MANUAL: cover property (sfr_wr && !sfr_sel && sfr_wdata[7]);
   COV_AUTO: cover property (sfr_wr && !sfr_sel && sfr_wdata[6] && !sfr_wdata[7]);
   COV_FROZEN: cover property (o_busy && !usb_clk_on);
endmodule // usbira_sva
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench for the indirect register access port, both ends
`timescale 1ns/10ps
`default_nettype none
module tb import usbira_pkg::*;;
   logic i_clk_sys, i_resetn, i_usb_clk_on, avs_read, avs_write, chk, avs_waitrequest, o_busy;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rq;
   logic [1:0] o_index;
   logic [7:0] d;
   logic [7:0] gen[16];
   logic [31:0] exp_q[$];
   int num_errors, checks, seed, i;

   usbira_if i_usbira_if();
   usbira_dev i_usbira_dev(.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .sfr(i_usbira_if),
      .i_usb_clk_on(i_usb_clk_on), .o_busy(o_busy), .o_index(o_index));
   usbira_cpu i_usbira_cpu(.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_avs_address(avs_address),
      .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
      .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest), .sfr(i_usbira_if));
   usbira_sva i_usbira_sva(.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .sfr_sel(i_usbira_if.sfr_sel),
      .sfr_wr(i_usbira_if.sfr_wr), .sfr_rd(i_usbira_if.sfr_rd), .sfr_wdata(i_usbira_if.sfr_wdata),
      .sfr_rdata(i_usbira_if.sfr_rdata), .usb_clk_on(i_usbira_if.usb_clk_on),
      .i_usb_clk_on(i_usb_clk_on), .o_busy(o_busy));

   initial begin
      i_clk_sys = 0;
      forever #5 i_clk_sys = ~i_clk_sys;
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task summarize;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Avalon master
   // ------------------------------------------------------------
   // Waitrequest and read data are taken at the rising edge that accepts the request
   task av(input logic rd, input logic [3:0] a, input logic [31:0] wd);
      int n;
      begin
         n = 0;
         @(posedge i_clk_sys);
         avs_address <= a;
         avs_read <= rd;
         avs_write <= !rd;
         avs_writedata <= wd;
         @(posedge i_clk_sys);
         while (avs_waitrequest !== 1'b0 && n < 50) begin
            @(posedge i_clk_sys);
            n++;
         end
         if (n >= 50) begin
            num_errors++;
            $display("ERROR %0t: bus wait timed out", $time);
         end
         rq = avs_readdata;
         avs_read <= 1'b0;
         avs_write <= 1'b0;
         chk = 1'b0;
      end
   endtask

   task rdchk(input logic [3:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      chk = 1'b1;
      av(1'b1, a, 32'h0);
   endtask

   task wait_done;
      int n;
      begin
         n = 0;
         rq = 32'h0;
         while ({rq[STAT_DONE_BIT], rq[STAT_BUSY_BIT]} !== 2'b10 && n < 300) begin
            av(1'b1, AV_STAT, 32'h0);
            n++;
         end
         if (n >= 300) begin
            num_errors++;
            $display("ERROR %0t: transfer never completed", $time);
         end
         av(1'b0, AV_STAT, 32'h2);
      end
   endtask

   task xfer(input logic wr, input logic au, input logic [5:0] t, input logic [7:0] dd);
      if (wr)
         av(1'b0, AV_WDATA, {24'h0, dd});
      av(1'b0, AV_CMD, {18'h0, t, 5'h0, au, wr, 1'b1});
      wait_done();
      if (!wr)
         rdchk(AV_RDATA, {24'h0, dd});
   endtask

   always @(negedge i_clk_sys) begin
      if (chk && avs_read && avs_waitrequest === 1'b0)
         check(avs_readdata, exp_q.pop_front());
   end

   initial begin
      repeat (60000) @(posedge i_clk_sys);
      num_errors++;
      $display("ERROR %0t: watchdog expired", $time);
      summarize();
   end

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      seed = 32'h7c0b;
      i_resetn = 1'b0;
      i_usb_clk_on = 1'b1;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      chk = 1'b0;
      num_errors = 0;
      checks = 0;
      repeat (20) @(posedge i_clk_sys);
      i_resetn <= 1'b1;
      repeat (3) @(posedge i_clk_sys);
      rdchk(AV_STAT, 32'h0);
      rdchk(4'h2, 32'h0);
      $display("test reset done");
      for (i = 1; i < 16; i++) begin
         d = $random(seed);
         gen[i] = d;
         xfer(1'b1, 1'b0, i[5:0], d);
      end
      for (i = 1; i < 16; i++)
         xfer(1'b0, i[0], i[5:0], gen[i]);
      xfer(1'b0, 1'b1, 6'd15, gen[15]);
      $display("test general registers done");
      for (i = 0; i < NUM_EP; i++) begin
         xfer(1'b1, 1'b0, CR_INDEX, i[7:0]);
         check({30'h0, o_index}, i[31:0]);
         xfer(1'b1, 1'b0, CR_EP_CSR1, 8'hA5 ^ i[7:0]);
      end
      for (i = 0; i < NUM_EP; i++) begin
         xfer(1'b1, 1'b0, CR_INDEX, i[7:0]);
         xfer(1'b0, 1'b0, CR_EP_CSR1, 8'hA5 ^ i[7:0]);
      end
      $display("test endpoint registers done");
      xfer(1'b1, 1'b0, CR_INDEX, 8'h01);
      for (i = 0; i <= FIFO_BYTES / NUM_EP; i++)
         xfer(1'b1, 1'b0, CR_FIFO, i[7:0]);
      xfer(1'b0, 1'b0, CR_EP_CNT, 8'hFF);
      xfer(1'b1, 1'b0, CR_INDEX, 8'h02);
      xfer(1'b0, 1'b0, CR_EP_CNT, 8'h00);
      xfer(1'b1, 1'b0, CR_INDEX, 8'h01);
      for (i = 0; i < FIFO_BYTES / NUM_EP; i++)
         xfer(1'b0, 1'b0, CR_FIFO, i[7:0]);
      xfer(1'b0, 1'b0, CR_EP_CNT, 8'h00);
      $display("test fifo done");
      d = $random(seed);
      av(1'b0, AV_WDATA, {24'h0, d});
      av(1'b0, AV_CMD, {18'h0, CR_GEN_LO, 8'h03});
      // The clock stops just before the data write reaches the port, which then holds busy
      repeat (2) @(posedge i_clk_sys);
      i_usb_clk_on <= 1'b0;
      repeat (30) @(posedge i_clk_sys);
      check({31'h0, o_busy}, 32'h1);
      rdchk(AV_STAT, 32'h2);
      av(1'b0, AV_STAT, 32'h2);
      gen[15] = $random(seed);
      av(1'b0, AV_WDATA, {24'h0, gen[15]});
      av(1'b0, AV_CMD, {18'h0, CR_GEN_HI, 8'h03});
      av(1'b0, AV_WDATA, 32'h0);
      rdchk(AV_STAT, 32'h1);
      i_usb_clk_on <= 1'b1;
      wait_done();
      xfer(1'b0, 1'b0, CR_GEN_LO, d);
      xfer(1'b0, 1'b0, CR_GEN_HI, gen[15]);
      $display("test stopped clock done");
      summarize();
   end
endmodule // tb
`default_nettype wire
